// ---- design/bert_pkg.sv ----
// Purpose: shared constants and types of the bit error rate tester
// Assumes: one 250 MHz clock, Avalon-MM register access with 32-bit data
// Notes:   register indexes are word indexes, byte address is four times the index
package bert_pkg;
    localparam int          BUS_ADDR_W      = 8;
    localparam int          BUS_DATA_W      = 32;
    localparam int          BUS_BE_W        = 4;
    localparam int          CLK_MHZ         = 250;

    localparam logic [5:0]  IDX_STATUS      = 6'h17;
    localparam logic [5:0]  IDX_ERR_LOW     = 6'h1a;
    localparam logic [5:0]  IDX_ERR_HIGH    = 6'h1b;
    localparam logic [5:0]  IDX_MODE        = 6'h1b;
    localparam logic [5:0]  IDX_FIFO_EN     = 6'h30;

    // mode register fields
    localparam int          MODE_PAT_LSB    = 0;
    localparam int          MODE_INJ_BIT    = 3;
    localparam int          MODE_AUTO_BIT   = 5;
    localparam int          MODE_WDEN_BIT   = 6;
    localparam int          MODE_KICK_BIT   = 7;
    // status register fields
    localparam int          STA_SRC_LSB     = 0;
    localparam int          STA_SYNC_BIT    = 4;
    localparam int          STA_INV_BIT     = 5;

    localparam logic [2:0]  PAT_ZEROS       = 3'h0;
    localparam logic [2:0]  PAT_ONES        = 3'h1;
    localparam logic [2:0]  PAT_9           = 3'h2;
    localparam logic [2:0]  PAT_10          = 3'h3;
    localparam logic [2:0]  PAT_15          = 3'h4;
    localparam logic [2:0]  PAT_20          = 3'h5;
    localparam logic [2:0]  PAT_20Z         = 3'h6;
    localparam logic [2:0]  PAT_23          = 3'h7;

    localparam int          N_FIFO          = 8;
    localparam int          BITS_MAX        = 8;
    localparam int          LFSR_W          = 23;
    localparam logic [4:0]  ZERO_RUN_MAX    = 5'h0e;
    localparam logic [7:0]  LOAD_BITS       = 8'h17;
    localparam logic [7:0]  ACQ_BITS        = 8'h40;
    localparam logic [7:0]  ACQ_ERR_MAX     = 8'h02;
    localparam logic [7:0]  WIN_ERR_MAX     = 8'h0a;

    localparam logic [2:0]  MODE_PAT_RST    = 3'h0;
    localparam logic [7:0]  FIFO_EN_RST     = 8'h00;
    localparam logic [22:0] LFSR_SEED       = 23'h7fffff;
    localparam logic [15:0] ERR_CNT_MAX     = 16'hffff;

    typedef enum logic [1:0] {RX_HUNT, RX_CHECK, RX_LOCK} bert_rx_phase_t;

    typedef struct packed {
        logic [22:0] lfsr;
        logic [4:0]  zeroRun;
    } bert_gen_st_t;

    typedef struct packed {
        bert_rx_phase_t phase;
        bert_gen_st_t   gen;
        logic [7:0]     bitCnt;
        logic [7:0]     errCnt;
        logic           inv;
    } bert_rx_st_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] fifo;
        logic [3:0] bitCnt;
    } bert_tx_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } bert_tx_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] fifo;
        logic [3:0] bitCnt;
        logic [7:0] data;
    } bert_rx_acc_t;

    typedef struct packed {
        logic autoKick;
        logic enable;
        logic kick;
    } bert_wd_t;
endpackage

// ---- design/bert_tester.sv ----
// Purpose: bit error rate tester, pattern generator, self-synchronising checker, counter
// Assumes: channel assigner presents one access per cycle, bits LSB first
// Notes:   bit count 0 or above 8 means a full byte
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module bert_tester
    import bert_pkg::*;
(
    input  wire logic                          clk,              // system clock
    input  wire logic                          nrst,             // sync reset, active low
    input  wire logic [bert_pkg::BUS_ADDR_W-1:0] avs_address,    // byte address
    input  wire logic                          avs_read,         // read request
    input  wire logic                          avs_write,        // write request
    input  wire logic [bert_pkg::BUS_BE_W-1:0] avs_byteenable,   // byte lanes
    input  wire logic [bert_pkg::BUS_DATA_W-1:0] avs_writedata,  // write data
    output logic      [bert_pkg::BUS_DATA_W-1:0] avs_readdata,   // read data
    output logic                               avs_waitrequest,  // stall
    input  wire logic [2:0]                    syncSrc,          // current sync source
    input  wire bert_pkg::bert_tx_req_t        txReq,            // transmit access
    output bert_pkg::bert_tx_rsp_t             txRsp,            // pattern bits
    input  wire bert_pkg::bert_rx_acc_t        rxAcc,            // receive access
    output bert_pkg::bert_wd_t                 wdCtrl            // watchdog control
);
    import bert_pkg::*;

    function automatic logic lfsrFb(input logic [22:0] s, input logic [2:0] pat);
        logic fb;
        fb = s[22] ^ s[17];
        case (pat)
            PAT_9:   fb = s[8] ^ s[4];
            PAT_10:  fb = s[9] ^ s[6];
            PAT_15:  fb = s[14] ^ s[13];
            PAT_20:  fb = s[19] ^ s[16];
            PAT_20Z: fb = s[19] ^ s[2];
            default: fb = s[22] ^ s[17];
        endcase
        return fb;
    endfunction

    // one generator step, returns {next state, output bit}
    function automatic logic [28:0] genStep(input bert_gen_st_t st, input logic [2:0] pat);
        bert_gen_st_t nst;
        logic         bitOut;
        logic         fb;
        nst = st;
        fb = lfsrFb(st.lfsr, pat);
        bitOut = fb;
        if (pat == PAT_ZEROS) begin
            bitOut = 1'b0;
        end else if (pat == PAT_ONES) begin
            bitOut = 1'b1;
        end else begin
            nst.lfsr = {st.lfsr[21:0], fb};
            if (pat == PAT_20Z && st.zeroRun >= ZERO_RUN_MAX) begin
                bitOut = 1'b1;
            end
        end
        if (bitOut) begin
            nst.zeroRun = 5'h00;
        end else if (st.zeroRun != 5'h1f) begin
            nst.zeroRun = st.zeroRun + 5'h01;
        end
        return {nst, bitOut};
    endfunction

    // registers
    logic [2:0]            modePat_r;
    logic                  injPend_r;
    logic                  autoKick_r;
    logic                  wdEn_r;
    logic [7:0]            fifoEn_r;
    logic [15:0]           errCnt_r;
    logic [7:0]            errHigh_r;
    logic [2:0]            syncSrc_r;
    bert_gen_st_t          gen_r;
    bert_rx_st_t           rx_r;
    logic                  waitReq_r;
    logic [BUS_DATA_W-1:0] rdData_r;
    bert_tx_rsp_t          txRsp_r;
    bert_wd_t              wd_r;

    // bus decode
    wire logic [5:0] regIdx   = avs_address[7:2];
    wire logic       busy     = (avs_read | avs_write) & waitReq_r;
    wire logic       rdAcc    = busy & avs_read;
    wire logic       wrAcc    = busy & avs_write & avs_byteenable[0];
    wire logic       rdErrLow = rdAcc & (regIdx == IDX_ERR_LOW);
    wire logic       wrMode   = wrAcc & (regIdx == IDX_MODE);
    wire logic       wrFifoEn = wrAcc & (regIdx == IDX_FIFO_EN);
    wire logic [7:0] wrByte   = avs_writedata[7:0];

    logic [7:0] statusByte;
    logic [7:0] rdMux;
    always_comb begin
        statusByte = 8'h00;
        statusByte[STA_SRC_LSB +: 3] = syncSrc_r;
        statusByte[STA_SYNC_BIT] = (rx_r.phase == RX_LOCK);
        statusByte[STA_INV_BIT] = rx_r.inv;
    end

    always_comb begin
        if (regIdx == IDX_STATUS) begin
            rdMux = statusByte;
        end else if (regIdx == IDX_ERR_LOW) begin
            rdMux = errCnt_r[7:0];
        end else if (regIdx == IDX_ERR_HIGH) begin
            rdMux = errHigh_r;
        end else if (regIdx == IDX_FIFO_EN) begin
            rdMux = fifoEn_r;
        end else begin
            rdMux = 8'h00;
        end
    end

    // transmit side: fill up to eight bits from the shared generator
    wire logic       txEnabled = txReq.valid & fifoEn_r[txReq.fifo];
    wire logic [3:0] txCount   = (txReq.bitCnt == 4'h0 || txReq.bitCnt > 4'h8) ?
                                 4'h8 : txReq.bitCnt;
    bert_gen_st_t genNxt;
    logic [7:0]   txByte;
    always_comb begin
        logic [28:0]  stepOut;
        bert_gen_st_t genCur;
        stepOut = 29'h0;
        genCur  = gen_r;
        txByte  = 8'h00;
        for (int i = 0; i < BITS_MAX; i++) begin
            if (txEnabled && i < int'(txCount)) begin
                stepOut   = genStep(genCur, modePat_r);
                genCur    = stepOut[28:1];
                txByte[i] = stepOut[0];
            end
        end
        if (txEnabled && injPend_r) begin
            txByte[0] = ~txByte[0];
        end
        genNxt = genCur;
    end

    // receive side: walk the bits of one access through the checker
    wire logic       rxEnabled = rxAcc.valid & fifoEn_r[rxAcc.fifo];
    wire logic [3:0] rxCount   = (rxAcc.bitCnt == 4'h0 || rxAcc.bitCnt > 4'h8) ?
                                 4'h8 : rxAcc.bitCnt;
    bert_rx_st_t rxNxt;
    logic [3:0]  errInc;
    always_comb begin
        bert_rx_st_t  st;
        logic [28:0]  stepOut;
        logic         rxBit;
        logic         pred;
        logic         mis;
        st      = rx_r;
        stepOut = 29'h0;
        rxBit   = 1'b0;
        pred    = 1'b0;
        mis     = 1'b0;
        errInc  = 4'h0;
        for (int i = 0; i < BITS_MAX; i++) begin
            if (rxEnabled && i < int'(rxCount)) begin
                rxBit   = rxAcc.data[i];
                stepOut = genStep(st.gen, modePat_r);
                pred    = stepOut[0];
                st.bitCnt = st.bitCnt + 8'h01;
                case (st.phase)
                    RX_HUNT: begin
                        // load history straight from the line
                        st.gen.lfsr = {st.gen.lfsr[21:0], rxBit};
                        if (st.bitCnt >= LOAD_BITS) begin
                            st.phase  = RX_CHECK;
                            st.bitCnt = 8'h00;
                            st.errCnt = 8'h00;
                        end
                    end
                    RX_CHECK: begin
                        // self-synchronous prediction, counts mismatches
                        st.gen.lfsr = {st.gen.lfsr[21:0], rxBit};
                        st.gen.zeroRun = stepOut[5:1];
                        if (rxBit != pred) begin
                            st.errCnt = st.errCnt + 8'h01;
                        end
                        if (st.bitCnt >= ACQ_BITS) begin
                            if (st.errCnt <= ACQ_ERR_MAX) begin
                                st.phase = RX_LOCK;
                                st.inv   = 1'b0;
                            end else if (st.errCnt >= ACQ_BITS - ACQ_ERR_MAX) begin
                                st.phase    = RX_LOCK;
                                st.inv      = 1'b1;
                                st.gen.lfsr = ~st.gen.lfsr;
                            end else begin
                                st.phase = RX_HUNT;
                            end
                            st.bitCnt = 8'h00;
                            st.errCnt = 8'h00;
                        end
                    end
                    default: begin
                        // locked: free-running reference
                        st.gen = stepOut[28:1];
                        mis    = (rxBit ^ st.inv) != pred;
                        if (mis) begin
                            errInc    = errInc + 4'h1;
                            st.errCnt = st.errCnt + 8'h01;
                        end
                        if (st.errCnt >= WIN_ERR_MAX) begin
                            st.phase  = RX_HUNT;
                            st.bitCnt = 8'h00;
                            st.errCnt = 8'h00;
                        end else if (st.bitCnt == 8'h00) begin
                            st.errCnt = 8'h00;
                        end
                    end
                endcase
            end
        end
        rxNxt = st;
    end

    // counter: clear on low read, new errors still land, saturating
    wire logic [15:0] cntBase = rdErrLow ? 16'h0000 : errCnt_r;
    wire logic [16:0] cntSum  = {1'b0, cntBase} + {13'h0000, errInc};
    wire logic [15:0] errCnt_nxt = cntSum[16] ? ERR_CNT_MAX : cntSum[15:0];

    wire logic injPend_nxt = (wrMode & wrByte[MODE_INJ_BIT]) |
                             (injPend_r & ~txEnabled);
    wire logic kick_nxt = (wrMode & wrByte[MODE_KICK_BIT]) |
                          (autoKick_r & busy);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            modePat_r  <= MODE_PAT_RST;
            injPend_r  <= 1'b0;
            autoKick_r <= 1'b0;
            wdEn_r     <= 1'b0;
            fifoEn_r   <= FIFO_EN_RST;
            syncSrc_r  <= 3'h0;
        end else begin
            if (wrMode) begin
                modePat_r  <= wrByte[MODE_PAT_LSB +: 3];
                autoKick_r <= wrByte[MODE_AUTO_BIT];
                wdEn_r     <= wrByte[MODE_WDEN_BIT];
            end
            if (wrFifoEn) begin
                fifoEn_r <= wrByte;
            end
            injPend_r <= injPend_nxt;
            syncSrc_r <= syncSrc;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            errCnt_r  <= 16'h0000;
            errHigh_r <= 8'h00;
            gen_r     <= '{lfsr: LFSR_SEED, zeroRun: 5'h00};
            rx_r      <= '{phase: RX_HUNT, gen: '{lfsr: LFSR_SEED, zeroRun: 5'h00},
                           bitCnt: 8'h00, errCnt: 8'h00, inv: 1'b0};
        end else begin
            errCnt_r <= errCnt_nxt;
            if (rdErrLow) begin
                errHigh_r <= errCnt_r[15:8];
            end
            gen_r <= genNxt;
            rx_r  <= rxNxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            waitReq_r <= 1'b1;
            rdData_r  <= 32'h0000_0000;
            txRsp_r   <= '{valid: 1'b0, data: 8'h00};
            wd_r      <= '{autoKick: 1'b0, enable: 1'b0, kick: 1'b0};
        end else begin
            waitReq_r <= ~busy;
            if (rdAcc) begin
                rdData_r <= {24'h000000, rdMux};
            end
            txRsp_r <= '{valid: txEnabled, data: txByte};
            wd_r    <= '{autoKick: autoKick_r, enable: wdEn_r, kick: kick_nxt};
        end
    end

    assign avs_readdata    = rdData_r;
    assign avs_waitrequest = waitReq_r;
    assign txRsp           = txRsp_r;
    assign wdCtrl          = wd_r;
endmodule
`default_nettype wire

// ---- sim/bert_checker.sv ----
// Purpose: port assertions of the bit error rate tester
// Assumes: bound to bert_tester, one clock domain
// Notes:   bus answers after exactly one wait cycle
`timescale 1ns/10ps
`default_nettype none
module bert_checker
    import bert_pkg::*;
(
    input wire logic                   clk,             // clock
    input wire logic                   nrst,            // reset, low
    input wire logic [7:0]             avs_address,     // address
    input wire logic                   avs_read,        // read
    input wire logic                   avs_write,       // write
    input wire logic [3:0]             avs_byteenable,  // lanes
    input wire logic [31:0]            avs_writedata,   // write data
    input wire logic [31:0]            avs_readdata,    // read data
    input wire logic                   avs_waitrequest, // stall
    input wire bert_pkg::bert_tx_req_t txReq,           // tx access
    input wire bert_pkg::bert_tx_rsp_t txRsp,           // tx bits
    input wire bert_pkg::bert_wd_t     wdCtrl           // watchdog
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    wire req = avs_read | avs_write;
    wire modeWr = avs_write & avs_waitrequest & avs_byteenable[0]
                  & (avs_address[7:2] == IDX_MODE);
    a_wait_once: assert property (req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("wait state not one cycle");
    a_wait_idle: assert property (!req && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    a_data_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_tx_idle: assert property (!txReq.valid |=> !txRsp.valid)
        else $error("tx bits without access");
    a_tx_width: assert property (txRsp.valid && $past(txReq.bitCnt) inside {[1:7]}
        |-> (txRsp.data >> $past(txReq.bitCnt)) == 8'h0)
        else $error("tx bits beyond bit count");
    a_kick_pulse: assert property (wdCtrl.kick |=> !wdCtrl.kick)
        else $error("kick longer than one cycle");
    a_kick_cause: assert property (modeWr && avs_writedata[7] |-> ##[1:2] wdCtrl.kick)
        else $error("kick missing after mode write");
    a_wd_level: assert property (modeWr |-> ##2 (wdCtrl.enable == $past(avs_writedata[6], 2)
        && wdCtrl.autoKick == $past(avs_writedata[5], 2)))
        else $error("watchdog levels not taken");
endmodule
bind bert_tester bert_checker i_chk (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest, .txReq, .txRsp, .wdCtrl);
`default_nettype wire

// ---- sim/bert_assigner_model.sv ----
// Purpose: channel assigner stand-in, issues tx accesses and loops data back
// Assumes: fifos visited 0 to 7, one access per cycle
// Notes:   invert and corrupt are commanded by the bench only
`timescale 1ns/10ps
`default_nettype none
module bert_assigner_model
    import bert_pkg::*;
(
    input wire logic                   clk,     // clock
    input wire logic                   nrst,    // reset, low
    input wire logic [3:0]             bitCnt,  // subchannel bits
    input wire logic                   invert,  // invert looped data
    input wire logic                   corrupt, // flip first bit
    output bert_pkg::bert_tx_req_t     txReq,   // tx access
    input wire bert_pkg::bert_tx_rsp_t txRsp,   // tx bits
    output bert_pkg::bert_rx_acc_t     rxAcc    // rx access
);
    logic [2:0] lastFifo_r;
    logic [3:0] lastCnt_r;
    wire  [7:0] flip = {{7{invert}}, invert ^ corrupt};
    always_ff @(posedge clk) begin
        if (!nrst) begin
            txReq      <= '0;
            rxAcc      <= '0;
            lastFifo_r <= 3'h0;
            lastCnt_r  <= 4'h0;
        end else begin
            // fifos in processing order
            txReq        <= '{1'b1, txReq.fifo + 3'h1, bitCnt};
            lastFifo_r   <= txReq.fifo;
            lastCnt_r    <= txReq.bitCnt;
            // looped back, never drained by software
            rxAcc.valid  <= txRsp.valid;
            rxAcc.fifo   <= lastFifo_r;
            rxAcc.bitCnt <= lastCnt_r;
            // bits pass XORed with flip (invert, corrupt on first bit), held data inverts when idle
            rxAcc.data   <= txRsp.valid ? txRsp.data ^ flip : ~rxAcc.data;
        end
    end
endmodule
`default_nettype wire

// ---- sim/bert_tester_tb.sv ----
// Purpose: self-checking bench of the bit error rate tester
// Assumes: assigner model loops transmit bits back to receive
// Notes:   pseudo random streams are judged by their recurrences, PAT_20Z only by its zero runs
`timescale 1ns/10ps
`default_nettype none
module bert_tester_tb
    import bert_pkg::*;
;
    logic         clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic         invert = 1'b0, corrupt = 1'b0, collect = 1'b0, avs_waitrequest;
    logic [7:0]   avs_address = 8'h0, fifoMask = 8'h0;
    logic [3:0]   avs_byteenable = 4'h0, bitCnt = 4'h8;
    logic [2:0]   syncSrc = 3'h0;
    logic [31:0]  avs_writedata = 32'h0, avs_readdata, d;
    bert_tx_req_t txReq, prevReq;
    bert_tx_rsp_t txRsp;
    bert_rx_acc_t rxAcc;
    bert_wd_t     wdCtrl;
    int           errCount = 0, numChecks = 0, cyc = 0, kicks = 0, k0;
    int           tapA[8] = '{0, 0, 9, 10, 15, 20, 0, 23};
    int           tapB[8] = '{0, 0, 5, 7, 14, 17, 0, 18};
    logic         bits[$];
    wire          expValid = prevReq.valid & fifoMask[prevReq.fifo];

    always #2 clk = ~clk;

    bert_tester i_dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .syncSrc, .txReq, .txRsp, .rxAcc,
        .wdCtrl);
    bert_assigner_model i_mdl (.clk, .nrst, .bitCnt, .invert, .corrupt, .txReq, .txRsp, .rxAcc);

    task automatic summarize();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       input logic [3:0] be);
        @(posedge clk);
        avs_address    <= {idx, 2'h0};
        avs_read       <= !wr;
        avs_write      <= wr;
        avs_writedata  <= {24'h0, wd};
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        d = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rdChk(input string what, input logic [5:0] idx, input logic [7:0] m,
                         input logic [7:0] exp);
        bus(1'b0, idx, 8'h0, 4'h1);
        chk(what, {24'h0, exp}, d & {24'h0, m});
    endtask

    task automatic waitSync(input logic inv);
        for (int k = 0; k < 300; k++) begin
            bus(1'b0, IDX_STATUS, 8'h0, 4'h1);
            if (d[4] === 1'b1)
                break;
        end
        chk("syncstate", {30'h0, inv, 1'b1}, {30'h0, d[5:4]});
    endtask

    task automatic patChk(input int p);
        int viol;
        int run;
        viol = int'(bits.size() < 40);
        run = 0;
        foreach (bits[k]) begin
            run = (bits[k] === 1'b0) ? run + 1 : 0;
            if (p < 2 && bits[k] !== p[0])
                viol++;
            if (p == 6 && run > 14)
                viol++;
            if (tapA[p] != 0 && k >= tapA[p] && bits[k] !== (bits[k-tapA[p]] ^ bits[k-tapB[p]]))
                viol++;
        end
        chk("pattern", 32'h0, 32'(viol));
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        prevReq <= txReq;
        kicks <= kicks + int'(wdCtrl.kick === 1'b1);
        if (cyc == 20000) begin
            errCount++;
            summarize();
        end
        if (collect) begin
            chk("txvalid", {31'h0, expValid}, {31'h0, txRsp.valid});
            if (txRsp.valid === 1'b1)
                for (int i = 0; i < 8 && (bitCnt > 8 || bitCnt == 0 || i < bitCnt); i++)
                    bits.push_back(txRsp.data[i]);
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int s = 0; s < 5; s++) begin
            syncSrc <= 3'(s);
            repeat (3) @(posedge clk);
            rdChk("status", IDX_STATUS, 8'hff, 8'(s));
        end
        rdChk("errlow", IDX_ERR_LOW, 8'hff, 8'h00);
        rdChk("errhigh", IDX_ERR_HIGH, 8'hff, 8'h00);
        rdChk("unmapped", 6'h05, 8'hff, 8'h00);
        bus(1'b1, IDX_MODE, 8'h80, 4'h1);
        repeat (3) @(posedge clk);
        chk("kicks", 32'h1, 32'(kicks));
        bus(1'b1, IDX_MODE, 8'h60, 4'h1);
        repeat (3) @(posedge clk);
        k0 = kicks;
        rdChk("idle", IDX_STATUS, 8'h00, 8'h00);
        repeat (3) @(posedge clk);
        chk("autokick", 32'h1, 32'(kicks - k0));
        chk("wdctrl", 32'h6, {29'h0, wdCtrl});
        bus(1'b1, IDX_MODE, 8'h00, 4'h1);
        fifoMask <= 8'h05;
        bus(1'b1, IDX_FIFO_EN, 8'h05, 4'h1);
        bus(1'b1, IDX_FIFO_EN, 8'hff, 4'h0);
        rdChk("fifoen", IDX_FIFO_EN, 8'hff, 8'h05);
        // last pass repeats the shortest sequence at three bits per access
        for (int p = 0; p < 9; p++) begin
            bitCnt <= (p == 8) ? 4'h3 : 4'h8;
            bus(1'b1, IDX_MODE, (p == 8) ? 8'h02 : 8'(p), 4'h1);
            repeat (6) @(posedge clk);
            bits.delete();
            collect <= 1'b1;
            repeat (100) @(posedge clk);
            collect <= 1'b0;
            @(posedge clk);
            patChk((p == 8) ? 2 : p);
        end
        bitCnt <= 4'h8;
        bus(1'b1, IDX_MODE, 8'h07, 4'h1);
        // let a lock held on the old pattern run out first
        repeat (100) @(posedge clk);
        waitSync(1'b0);
        bus(1'b0, IDX_ERR_LOW, 8'h0, 4'h1);
        rdChk("errlow", IDX_ERR_LOW, 8'hff, 8'h00);
        bus(1'b1, IDX_MODE, 8'h0f, 4'h1);
        repeat (20) @(posedge clk);
        rdChk("inject", IDX_ERR_LOW, 8'hff, 8'h01);
        rdChk("errhigh", IDX_ERR_HIGH, 8'hff, 8'h00);
        rdChk("cleared", IDX_ERR_LOW, 8'hff, 8'h00);
        invert <= 1'b1;
        repeat (40) @(posedge clk);
        waitSync(1'b1);
        invert <= 1'b0;
        repeat (40) @(posedge clk);
        waitSync(1'b0);
        corrupt <= 1'b1;
        repeat (200) @(posedge clk);
        rdChk("lost", IDX_STATUS, 8'h10, 8'h00);
        bus(1'b0, IDX_ERR_LOW, 8'h0, 4'h1);
        chk("burst", 32'h1, {31'h0, d[7:0] != 8'h0});
        corrupt <= 1'b0;
        repeat (40) @(posedge clk);
        waitSync(1'b0);
        bitCnt <= 4'h3;
        fifoMask <= 8'h81;
        bus(1'b1, IDX_FIFO_EN, 8'h81, 4'h1);
        repeat (300) @(posedge clk);
        waitSync(1'b0);
        bus(1'b0, IDX_ERR_LOW, 8'h0, 4'h1);
        repeat (200) @(posedge clk);
        rdChk("subchan", IDX_ERR_LOW, 8'hff, 8'h00);
        rdChk("insync", IDX_STATUS, 8'h30, 8'h10);
        summarize();
    end
endmodule
`default_nettype wire
